// ==== verilog/usf_slave.sv ====
// Slave frame front end: address choice, frame parsing, register access and reply.
// Contract
// - Internal select set: address from stored value.
// - Internal select set: pins become dimming inputs.
// - Internal select clear: stored bit3 plus pins.
// - Stored bit3 resets per variant.
// - Verified unicast frame answers read data (reads only), status, then CRC.
// - Broadcast frames get no answer.
// - Bit timing learned from the preamble.
// - Target-select byte follows preamble, low nibble address.
// - Bits 5-4 give payload length 1/2/4/8.
// - Bit 6 broadcasts only with address zero.
// - Bit 7 high writes, low reads.
// - Register index byte follows target-select.
// - Write data byte count matches length field; read frames carry no data bytes.
// - Every frame CRC checked before acting.
// - Bytes are start, eight LSB-first, stop.
// - CRC mismatch: drop frame, no watchdog refresh.
// - Mid-frame idle past timeout restarts at preamble.
// - Burst bytes go to consecutive indices.
`default_nettype none
`include "usf_params.svh"
module usf_slave
  import usf_pkg::*;
#(
  parameter bit ALT_VARIANT = 1'b0
) (
  input wire logic core_clk,                       // System clock, 100 MHz.
  input wire logic nrst,                           // Asynchronous reset, active low.
  input wire logic rx_pin,                         // Link receive line, idle high.
  input wire logic [2:0] address_pins,             // Address pins 2..0.
  input wire logic internal_address_select,        // Stored address select.
  input wire logic [3:0] stored_slave_address,     // Stored address value.
  input wire logic stored_addr_load,               // Load stored address.
  input wire logic [`USF_CNT_W-1:0] frame_idle_timeout, // Idle timeout in cycles, 0 disables.
  input wire logic [7:0] status_flag_register,     // Status byte for replies.
  input wire logic [7:0] reg_rdata,                // Register read data.
  output logic tx_pin,                             // Link transmit line.
  output logic tx_oe,                              // Transmit drive enable.
  output logic reg_wr,                             // Register write strobe.
  output logic reg_rd,                             // Register read strobe.
  output logic [7:0] reg_idx,                      // Register index.
  output logic [7:0] reg_wdata,                    // Register write data.
  output logic wd_refresh,                         // Link watchdog refresh pulse.
  output logic ext_dim_clk,                        // Dimming generator clock.
  output logic external_dimming_input_a,           // Dimming input a.
  output logic external_dimming_input_b,           // Dimming input b.
  output logic [3:0] slave_addr                    // Resolved slave address.
);
  localparam usf_st_s RST = '{st: ST_IDLE, txk: TK_DATA, rx1: 1'b1, rx2: 1'b1, rx3: 1'b1, rxf: 1'b1,
                              rxp: 1'b1, stored: {ALT_VARIANT, 3'h0}, tx: 1'b1, default: '0};

  usf_st_s s;
  usf_st_s n;
  usf_fbuf_if fb ();

  usf_fbuf u_fbuf (
    .core_clk(core_clk),
    .nrst(nrst),
    .fb(fb.mem)
  );

  logic fall;
  logic last_bit;
  logic is_crc;
  logic crc_ok;
  logic accept;
  logic go;
  logic [7:0] tb;
  logic [3:0] len;

  assign fall = s.rxp && !s.rxf;
  assign len = usf_len(s.tsel);
  assign last_bit = (s.st == ST_BIT) && (s.cnt == '0) && (s.bitn == `USF_STOP_BIT) && s.rxf;
  assign is_crc = (s.bi >= `USF_HDR_BYTES) && !(s.tsel[`USF_WR_BIT] && (s.bi - `USF_HDR_BYTES) < len);
  assign crc_ok = (s.sh == s.crc);
  assign accept = usf_bcast(s.tsel) || (s.tsel[3:0] == s.addr);
  assign fb.we = s.fwe;
  assign fb.wa = s.fwa;
  assign fb.wd = s.fwd;
  assign fb.ra = s.i[2:0];

  always_comb begin
    n = s;
    go = 1'b0;
    tb = '0;
    n.rx1 = rx_pin;
    n.rx2 = s.rx1;
    n.rx3 = s.rx2;
    n.ap1 = address_pins;
    n.ap2 = s.ap1;
    n.ap3 = s.ap2;
    if (s.rx2 == s.rx3) begin
      n.rxf = s.rx3;
    end
    if (s.ap2 == s.ap3) begin
      n.apf = s.ap3;
    end
    n.rxp = s.rxf;
    if (stored_addr_load) begin
      n.stored = stored_slave_address;
    end
    n.addr = internal_address_select ? s.stored : {s.stored[3], s.apf};
    n.eclk = internal_address_select & s.apf[2];
    n.dima = internal_address_select & s.apf[1];
    n.dimb = internal_address_select & s.apf[0];
    n.reg_wr = 1'b0;
    n.reg_rd = 1'b0;
    n.wdr = 1'b0;
    n.fwe = 1'b0;
    case (s.st)
      ST_IDLE: begin
        n.oe = 1'b0;
        n.tx = 1'b1;
        n.resp = 1'b0;
        if (fall) begin
          n.cnt = '0;
          n.edges = '0;
          n.st = ST_SYNC;
        end
      end
      ST_SYNC: begin
        n.cnt = s.cnt + 1'b1;
        if (fall) begin
          n.edges = s.edges + 1'b1;
          // The fifth falling edge of a 01010101 preamble lies eight bit times after the first.
          if (s.edges == `USF_SYNC_EDGES - 3'h1) begin
            n.per = `USF_PER_W'((s.cnt + 1'b1) >> `USF_SYNC_SHIFT);
            n.bi = '0;
            n.crc = `USF_CRC_INIT;
            n.st = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        if (fall) begin
          n.cnt = `USF_CNT_W'(s.per >> 1);
          n.bitn = '0;
          n.st = ST_BIT;
        end
      end
      ST_BIT: begin
        if (s.cnt != '0) begin
          n.cnt = s.cnt - 1'b1;
        end else begin
          n.cnt = `USF_CNT_W'(s.per - 1'b1);
          n.bitn = s.bitn + 1'b1;
          if (s.bitn == '0 && s.rxf) begin
            n.st = ST_WAIT;
          end else if (s.bitn != `USF_STOP_BIT) begin
            if (s.bitn != '0) begin
              n.sh = {s.rxf, s.sh[7:1]};
            end
          end else if (!s.rxf) begin
            n.st = ST_IDLE;
          end else begin
            n.st = ST_WAIT;
            n.bi = s.bi + 1'b1;
            if (s.bi == '0) begin
              n.tsel = s.sh;
              n.crc = usf_crc8(s.crc, s.sh);
            end else if (s.bi == 4'h1) begin
              n.idx = s.sh;
              n.crc = usf_crc8(s.crc, s.sh);
            end else if (!is_crc) begin
              n.fwe = 1'b1;
              n.fwa = 3'(s.bi - `USF_HDR_BYTES);
              n.fwd = s.sh;
              n.crc = usf_crc8(s.crc, s.sh);
            end else begin
              n.st = ST_IDLE;
              n.i = '0;
              n.ph = 1'b0;
              n.txk = s.tsel[`USF_WR_BIT] ? TK_STAT : TK_DATA;
              n.tcrc = `USF_CRC_INIT;
              if (crc_ok && accept) begin
                n.wdr = 1'b1;
                n.resp = !usf_bcast(s.tsel);
                if (s.tsel[`USF_WR_BIT]) begin
                  n.st = ST_EXEC;
                end else if (!usf_bcast(s.tsel)) begin
                  n.st = ST_NEXT;
                end
              end
            end
          end
        end
      end
      ST_EXEC: begin
        // Buffer read data lag the read address by one cycle, so writes go out every other cycle.
        n.ph = !s.ph;
        if (s.ph) begin
          n.reg_wr = 1'b1;
          n.reg_idx = s.idx + {4'h0, s.i};
          n.reg_wdata = fb.rd;
          n.i = s.i + 1'b1;
          if (s.i == len - 1'b1) begin
            n.st = s.resp ? ST_NEXT : ST_IDLE;
          end
        end
      end
      ST_RD: begin
        n.reg_rd = 1'b1;
        n.reg_idx = s.idx + {4'h0, s.i};
        n.st = ST_RDW;
      end
      ST_RDW: begin
        tb = reg_rdata;
        go = 1'b1;
        n.i = s.i + 1'b1;
      end
      ST_NEXT: begin
        case (s.txk)
          TK_DATA: begin
            if (s.i != len) begin
              n.st = ST_RD;
            end else begin
              tb = status_flag_register;
              go = 1'b1;
              n.txk = TK_CRC;
            end
          end
          TK_STAT: begin
            tb = status_flag_register;
            go = 1'b1;
            n.txk = TK_CRC;
          end
          TK_CRC: begin
            tb = s.tcrc;
            go = 1'b1;
            n.txk = TK_END;
          end
          default: begin
            n.st = ST_IDLE;
          end
        endcase
      end
      ST_TX: begin
        if (s.cnt != '0) begin
          n.cnt = s.cnt - 1'b1;
        end else if (s.bitn == `USF_STOP_BIT) begin
          n.st = ST_NEXT;
        end else begin
          n.cnt = `USF_CNT_W'(s.per - 1'b1);
          n.bitn = s.bitn + 1'b1;
          n.tx = s.txsh[0];
          n.txsh = {1'b1, s.txsh[8:1]};
        end
      end
      default: begin
        n.st = ST_IDLE;
      end
    endcase
    if (go) begin
      n.txsh = {1'b1, tb};
      n.tcrc = usf_crc8(s.tcrc, tb);
      n.tx = 1'b0;
      n.oe = 1'b1;
      n.bitn = '0;
      n.cnt = `USF_CNT_W'(s.per - 1'b1);
      n.st = ST_TX;
    end
    // Only line changes re-arm the idle timer; a master that stalls mid-frame loses the frame.
    if (s.st inside {ST_SYNC, ST_WAIT, ST_BIT} && s.rxf == s.rxp) begin
      n.idle = s.idle + 1'b1;
      if (frame_idle_timeout != '0 && s.idle >= frame_idle_timeout) begin
        n.st = ST_IDLE;
        n.idle = '0;
      end
    end else begin
      n.idle = '0;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s <= RST;
    end else begin
      s <= n;
    end
  end

  assign tx_pin = s.tx;
  assign tx_oe = s.oe;
  assign reg_wr = s.reg_wr;
  assign reg_rd = s.reg_rd;
  assign reg_idx = s.reg_idx;
  assign reg_wdata = s.reg_wdata;
  assign wd_refresh = s.wdr;
  assign ext_dim_clk = s.eclk;
  assign external_dimming_input_a = s.dima;
  assign external_dimming_input_b = s.dimb;
  assign slave_addr = s.addr;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  sequence crc_pass;
    last_bit && is_crc && crc_ok && accept;
  endsequence

  sequence crc_fail;
    last_bit && is_crc && !crc_ok;
  endsequence

  a_addr_stored: assert property (internal_address_select |=> slave_addr == $past(s.stored))
    else $error("stored address not used");
  a_addr_pins: assert property (!internal_address_select |=> slave_addr == {$past(s.stored[3]), $past(s.apf)})
    else $error("pin address wrong");
  a_pin_reuse: assert property (internal_address_select |=>
      ext_dim_clk == $past(s.apf[2]) && external_dimming_input_a == $past(s.apf[1])
      && external_dimming_input_b == $past(s.apf[0]))
    else $error("pins not repurposed");
  a_variant_reset: assert property (@(posedge core_clk) $rose(nrst) |-> s.stored[3] == ALT_VARIANT)
    else $error("stored bit3 reset wrong");
  a_pass_refresh: assert property (crc_pass |=> wd_refresh && s.resp == !usf_bcast($past(s.tsel)))
    else $error("accepted frame not refreshed");
  a_fail_drop: assert property (crc_fail |=> !wd_refresh && s.st == ST_IDLE ##1 !tx_oe)
    else $error("bad crc acted on");
  a_tx_gated: assert property ($rose(tx_oe) |-> s.resp && !usf_bcast(s.tsel))
    else $error("reply without accepted unicast");
  a_status_byte: assert property ((s.st == ST_NEXT && s.txk == TK_STAT)
      |=> s.txsh[7:0] == $past(status_flag_register))
    else $error("status byte wrong");
  a_burst_index: assert property (reg_wr ##2 reg_wr |-> reg_idx == $past(reg_idx, 2) + 8'h01)
    else $error("burst index not consecutive");
  a_idle_abort: assert property ((s.st inside {ST_SYNC, ST_WAIT, ST_BIT} && s.rxf == s.rxp
      && frame_idle_timeout != '0 && s.idle >= frame_idle_timeout) |=> s.st == ST_IDLE)
    else $error("idle frame not dropped");
  a_read_first: assert property ((s.st == ST_NEXT && s.txk == TK_DATA && s.i != len)
      |=> s.st == ST_RD ##1 (reg_rd && s.st == ST_RDW))
    else $error("read data not fetched first");
  a_tx_start: assert property ($rose(tx_oe) |-> !tx_pin ##1 !tx_pin)
    else $error("start bit missing");
endmodule : usf_slave
`default_nettype wire

// ==== verilog/usf_params.svh ====
// Constants shared by the slave frame front end.
`ifndef USF_PARAMS_SVH
`define USF_PARAMS_SVH
`define USF_CRC_INIT 8'hFF
`define USF_CRC_POLY 8'h31
`define USF_BC_BIT 6
`define USF_WR_BIT 7
`define USF_LEN_LSB 4
`define USF_SYNC_EDGES 3'h4
`define USF_SYNC_SHIFT 3
`define USF_STOP_BIT 4'h9
`define USF_HDR_BYTES 4'h2
`define USF_BC_ADDR 4'h0
`define USF_CNT_W 20
`define USF_PER_W 16
`endif

// ==== verilog/usf_pkg.sv ====
// Types and helper functions of the slave frame front end.
`default_nettype none
`include "usf_params.svh"
package usf_pkg;
  typedef enum logic [3:0] {ST_IDLE, ST_SYNC, ST_WAIT, ST_BIT, ST_EXEC, ST_RD, ST_RDW, ST_NEXT, ST_TX} usf_st_e;
  typedef enum logic [1:0] {TK_DATA, TK_STAT, TK_CRC, TK_END} usf_txk_e;

  typedef struct packed {
    usf_st_e st;
    usf_txk_e txk;
    logic rx1, rx2, rx3, rxf, rxp;
    logic [2:0] ap1, ap2, ap3, apf;
    logic [`USF_CNT_W-1:0] cnt, idle;
    logic [`USF_PER_W-1:0] per;
    logic [2:0] edges;
    logic [3:0] bitn, bi, i, stored, addr;
    logic [7:0] sh, tsel, idx, crc, tcrc;
    logic [8:0] txsh;
    logic ph, resp, tx, oe, reg_wr, reg_rd, wdr, eclk, dima, dimb, fwe;
    logic [7:0] reg_idx, reg_wdata, fwd;
    logic [2:0] fwa;
  } usf_st_s;

  // One byte of an MSB-first CRC-8, shared by the receive check and the reply.
  function automatic logic [7:0] usf_crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int k = 0; k < 8; k++) begin
      r = r[7] ? ((r << 1) ^ `USF_CRC_POLY) : (r << 1);
    end
    return r;
  endfunction : usf_crc8

  function automatic logic [3:0] usf_len(input logic [7:0] t);
    return 4'(4'h1 << t[`USF_LEN_LSB +: 2]);
  endfunction : usf_len

  function automatic logic usf_bcast(input logic [7:0] t);
    return t[`USF_BC_BIT] && (t[3:0] == `USF_BC_ADDR);
  endfunction : usf_bcast
endpackage : usf_pkg
`default_nettype wire

// ==== verilog/usf_fbuf_if.sv ====
// Port bundle between the frame parser and its payload buffer.
`default_nettype none
interface usf_fbuf_if;
  logic we;
  logic [2:0] wa;
  logic [7:0] wd;
  logic [2:0] ra;
  logic [7:0] rd;
  modport ctrl (output we, output wa, output wd, output ra, input rd);
  modport mem (input we, input wa, input wd, input ra, output rd);
endinterface : usf_fbuf_if
`default_nettype wire

// ==== verilog/usf_fbuf.sv ====
// Eight-byte payload buffer with registered read data.
`default_nettype none
module usf_fbuf
  import usf_pkg::*;
(
  input wire logic core_clk, // System clock.
  input wire logic nrst,     // Asynchronous reset, active low.
  usf_fbuf_if.mem fb         // Write and read port.
);
  typedef struct packed {
    logic [7:0][7:0] m;
    logic [7:0] rd;
  } usf_fb_s;

  usf_fb_s s;
  usf_fb_s n;

  always_comb begin
    n = s;
    if (fb.we) begin
      n.m[fb.wa] = fb.wd;
    end
    n.rd = s.m[fb.ra];
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign fb.rd = s.rd;
endmodule : usf_fbuf
`default_nettype wire

// ==== tb/usf_master_model.sv ====
// Link master model: frames bytes onto the slave's receive line and collects its replies.
`default_nettype none
module usf_master_model #(
  parameter int PER = 16
) (
  input wire logic core_clk, // System clock.
  output var logic rx_pin,   // Line towards the slave, idle high.
  input wire logic tx_pin    // Reply line from the slave.
);
  timeunit 1ns;
  timeprecision 1ps;

  initial rx_pin = 1'b1;

  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int k = 0; k < 8; k++) begin
      r = r[7] ? ((r << 1) ^ 8'h31) : (r << 1);
    end
    return r;
  endfunction : crc_step

  // The stop bit is cut to half a period so a caller can watch for a prompt reply.
  task automatic send_byte(input logic [7:0] b);
    repeat (PER / 2) @(posedge core_clk);
    for (int k = -1; k < 9; k++) begin
      rx_pin <= (k < 0) ? 1'b0 : (k > 7) ? 1'b1 : b[k];
      repeat (k > 7 ? PER / 2 : PER) @(posedge core_clk);
    end
  endtask : send_byte

  task automatic send_frame(input logic [7:0] tsel, input logic [7:0] idx, input logic [63:0] data,
                            input logic bad);
    logic [7:0] c;
    int n;
    n = tsel[7] ? (1 << tsel[5:4]) : 0;
    c = crc_step(crc_step(8'hFF, tsel), idx);
    send_byte(8'h55);
    send_byte(tsel);
    send_byte(idx);
    for (int k = 0; k < n; k++) begin
      send_byte(data[8*k +: 8]);
      c = crc_step(c, data[8*k +: 8]);
    end
    send_byte(bad ? ~c : c);
  endtask : send_frame

  task automatic recv_byte(output logic [7:0] b, output logic ok);
    int w;
    w = 0;
    ok = 1'b0;
    b = 8'h00;
    while (tx_pin !== 1'b0 && w < 40 * PER) begin
      @(posedge core_clk);
      w++;
    end
    if (tx_pin === 1'b0) begin
      repeat (PER / 2) @(posedge core_clk);
      for (int k = 0; k < 8; k++) begin
        repeat (PER) @(posedge core_clk);
        b[k] = tx_pin;
      end
      repeat (PER) @(posedge core_clk);
      ok = (tx_pin === 1'b1);
    end
  endtask : recv_byte
endmodule : usf_master_model
`default_nettype wire

// ==== tb/usf_slave_tb.sv ====
// Self-checking bench for the slave frame front end.
`default_nettype none
`include "usf_params.svh"
`define TB_CHK(name, exp, got) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
      err_total++; \
      $display("BAD %s expected %0h seen %0h", name, exp, got); \
    end \
  end
module usf_slave_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PER = 16;
  logic core_clk, nrst, rx_pin, internal_address_select, stored_addr_load;
  logic [2:0] address_pins;
  logic [3:0] stored_slave_address, slave_addr;
  logic [`USF_CNT_W-1:0] frame_idle_timeout;
  logic [7:0] status_flag_register, reg_rdata, reg_idx, reg_wdata, wr_base;
  logic tx_pin, tx_oe, tx_oe_q, reg_wr, reg_rd, wd_refresh, dim_clk, dim_a, dim_b;
  logic [63:0] wr_data;
  int err_total, cmp_count, wr_cnt, rd_cnt, wd_cnt, oe_cnt;

  usf_slave i_dut (
    .core_clk(core_clk), .nrst(nrst), .rx_pin(rx_pin), .address_pins(address_pins),
    .internal_address_select(internal_address_select), .stored_slave_address(stored_slave_address),
    .stored_addr_load(stored_addr_load), .frame_idle_timeout(frame_idle_timeout),
    .status_flag_register(status_flag_register), .reg_rdata(reg_rdata), .tx_pin(tx_pin), .tx_oe(tx_oe),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_idx(reg_idx), .reg_wdata(reg_wdata), .wd_refresh(wd_refresh),
    .ext_dim_clk(dim_clk), .external_dimming_input_a(dim_a), .external_dimming_input_b(dim_b),
    .slave_addr(slave_addr)
  );
  usf_master_model #(.PER(PER)) i_mst (.core_clk(core_clk), .rx_pin(rx_pin), .tx_pin(tx_pin));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Read data is a fixed function of the index so every byte of a burst differs.
  assign reg_rdata = reg_idx ^ 8'hC3;

  always @(posedge core_clk) begin
    tx_oe_q <= tx_oe;
    if (tx_oe === 1'b1 && tx_oe_q !== 1'b1) oe_cnt++;
    if (wd_refresh === 1'b1) wd_cnt++;
    if (reg_wr === 1'b1) begin
      `TB_CHK("reg_idx", wr_base + 8'(wr_cnt), reg_idx)
      `TB_CHK("reg_wdata", wr_data[8*wr_cnt +: 8], reg_wdata)
      wr_cnt++;
    end
    if (reg_rd === 1'b1) begin
      `TB_CHK("rd_idx", wr_base + 8'(rd_cnt), reg_idx)
      rd_cnt++;
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test

  // Sends one frame, then judges refresh, write strobes and the reply; nrep < 0 means no reply.
  task automatic frame_chk(input logic [7:0] tsel, input logic [7:0] idx, input logic bad,
                           input int acc, input int nwr, input int nrep);
    logic [7:0] b, e, c;
    logic ok;
    int wd0, oe0;
    wd0 = wd_cnt;
    oe0 = oe_cnt;
    wr_cnt = 0;
    rd_cnt = 0;
    wr_base = idx;
    c = 8'hFF;
    i_mst.send_frame(tsel, idx, wr_data, bad);
    for (int k = 0; k <= nrep + 1 && nrep >= 0; k++) begin
      e = (k < nrep) ? ((idx + 8'(k)) ^ 8'hC3) : (k == nrep) ? status_flag_register : c;
      i_mst.recv_byte(b, ok);
      `TB_CHK("reply_stop", 1'b1, ok)
      `TB_CHK("reply_byte", e, b)
      c = i_mst.crc_step(c, e);
    end
    repeat (40 * PER) @(posedge core_clk);
    `TB_CHK("refresh", acc, wd_cnt - wd0)
    `TB_CHK("writes", nwr, wr_cnt)
    `TB_CHK("reads", (nrep > 0) ? nrep : 0, rd_cnt)
    `TB_CHK("replies", int'(nrep >= 0), oe_cnt - oe0)
  endtask : frame_chk

  task automatic t_addr();
    `TB_CHK("addr_reset", 4'h5, slave_addr)
    stored_slave_address <= 4'hA;
    stored_addr_load <= 1'b1;
    @(posedge core_clk);
    stored_addr_load <= 1'b0;
    repeat (6) @(posedge core_clk);
    `TB_CHK("addr_pins", 4'hD, slave_addr)
    internal_address_select <= 1'b1;
    repeat (6) @(posedge core_clk);
    `TB_CHK("addr_stored", 4'hA, slave_addr)
    `TB_CHK("dim_pins", 3'h5, {dim_clk, dim_a, dim_b})
    address_pins <= 3'h2;
    repeat (6) @(posedge core_clk);
    `TB_CHK("addr_hold", 4'hA, slave_addr)
    `TB_CHK("dim_pins2", 3'h2, {dim_clk, dim_a, dim_b})
    address_pins <= 3'h5;
    repeat (6) @(posedge core_clk);
    internal_address_select <= 1'b0;
    stored_slave_address <= 4'h2;
    stored_addr_load <= 1'b1;
    @(posedge core_clk);
    stored_addr_load <= 1'b0;
    repeat (6) @(posedge core_clk);
    `TB_CHK("addr_back", 4'h5, slave_addr)
    `TB_CHK("dim_off", 3'h0, {dim_clk, dim_a, dim_b})
  endtask : t_addr

  task automatic t_writes();
    for (int lc = 0; lc < 4; lc++) begin
      status_flag_register <= 8'h40 | 8'(lc);
      frame_chk({2'b10, 2'(lc), 4'h5}, 8'hFD, 1'b0, 1, 1 << lc, 0);
    end
  endtask : t_writes

  task automatic t_reads();
    for (int lc = 0; lc < 4; lc++) begin
      frame_chk({2'b00, 2'(lc), 4'h5}, 8'hFE, 1'b0, 1, 0, 1 << lc);
    end
  endtask : t_reads

  task automatic t_drop();
    frame_chk(8'h95, 8'h10, 1'b1, 0, 0, -1);
    frame_chk(8'hC0, 8'h10, 1'b1, 0, 0, -1);
    frame_chk(8'h96, 8'h10, 1'b0, 0, 0, -1);
    frame_chk(8'hC3, 8'h10, 1'b0, 0, 0, -1);
  endtask : t_drop

  task automatic t_bcast();
    frame_chk(8'hD0, 8'h20, 1'b0, 1, 2, -1);
    frame_chk(8'h40, 8'h20, 1'b0, 1, 0, -1);
  endtask : t_bcast

  task automatic t_timeout();
    i_mst.send_byte(8'h55);
    i_mst.send_byte(8'h85);
    repeat (450) @(posedge core_clk);
    frame_chk(8'h85, 8'h33, 1'b0, 1, 1, 0);
  endtask : t_timeout

  initial begin
    repeat (80000) @(posedge core_clk);
    err_total++;
    finish_test();
  end

  initial begin
    nrst = 1'b0;
    address_pins = 3'h5;
    internal_address_select = 1'b0;
    stored_slave_address = 4'h0;
    stored_addr_load = 1'b0;
    frame_idle_timeout = `USF_CNT_W'(300);
    status_flag_register = 8'hA6;
    wr_data = 64'h0123456789ABCDEF;
    tx_oe_q = 1'b0;
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (8) @(posedge core_clk);
    t_addr();
    t_writes();
    t_reads();
    t_drop();
    t_bcast();
    t_timeout();
    finish_test();
  end
endmodule : usf_slave_tb
`default_nettype wire
